// ==== rtl/fpt_consts.svh ====
// Offsets, field positions, reset values and timing counts of the flash protection block.
`ifndef FPT_CONSTS_SVH
`define FPT_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FPT_OFF_ADDR 8'h00
`define FPT_OFF_DATA 8'h04
`define FPT_OFF_CTRL 8'h08
`define FPT_OFF_RIS 8'h0C
`define FPT_OFF_IM 8'h10
`define FPT_OFF_MIS 8'h14
`define FPT_OFF_MISC 8'h18
`define FPT_OFF_USEC 8'h20
`define FPT_OFF_RP0 8'h40
`define FPT_OFF_PP0 8'h50
// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define FPT_KEY 16'hA442
`define FPT_CTL_WRITE 0
`define FPT_CTL_ERASE 1
`define FPT_CTL_MERASE 2
`define FPT_CTL_COMMIT 3
`define FPT_INT_ACC 0
`define FPT_INT_PRG 1
`define FPT_ONES 32'hFFFFFFFF
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPT_CLK_MHZ 50
`define FPT_USEC_RST (`FPT_CLK_MHZ - 1)
`define FPT_WRITE_US 8'h02
// ----------------------------------------------------------------
// Memory map
// ----------------------------------------------------------------
`define FPT_SRAM_BASE 32'h20000000
`define FPT_BB_BASE 32'h22000000
`define FPT_BB_MASK 32'hFE000000
`define FPT_BLK_LAST 8'hFF
`define FPT_FLASH_LAST 16'hFFFF
`endif

// ==== rtl/fpt_pkg.sv ====
// Types shared by the flash protection block.
package fpt_pkg;
  // Program/erase engine states, Gray along each path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD = 3'b001,
    ST_WAIT = 3'b011,
    ST_PROG = 3'b010,
    ST_ERASE = 3'b100
  } fpt_state_e;
  typedef logic [31:0] fpt_word_t;
endpackage : fpt_pkg

// ==== rtl/fpt_flash_mem.sv ====
// Flash word array with a registered read port.
`timescale 1ns/1ps
module fpt_flash_mem (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Access port
  input wire logic re,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire fpt_pkg::fpt_word_t wdata,
  output fpt_pkg::fpt_word_t rdata
);
  fpt_pkg::fpt_word_t mem [0:65535];
  fpt_pkg::fpt_word_t next_rdata;

  // Read data only moves on a read, so the engine can hold the old word.
  always_comb begin
    next_rdata = re ? mem[addr] : rdata;
  end

  // The array itself has no reset: flash contents survive every reset.
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Read register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule : fpt_flash_mem

// ==== rtl/fpt_flash_protect.sv ====
// Flash protection, program/erase timing and bit-band decode with an AHB-Lite register port.
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "fpt_consts.svh"
// Notes on behaviour
// - Erase sets every bit of 1-KB block.
// - Programming a word only clears bits.
// - Two erase blocks share one 2-KB policy.
// - Read and program bit per block, four words.
// - Program bit one permits change, zero refuses.
// - Read bit zero permits only instruction fetches.
// - Program one, read zero: no data reads.
// - Program zero, read one: no writes/erases.
// - Blocked data read returns a bus fault.
// - Blocked program/erase flags masked access interrupt.
// - Software only clears; commit makes it permanent.
// - Power-on reset restores uncommitted cleared bits.
// - SRAM starts at the SRAM base address.
// - Bit-band alias reaches one bit atomically.
// - Raw status readable; write one clears both.
// - Fetches stall while an operation runs.
module fpt_flash_protect (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  input wire logic nv_blank_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire fpt_pkg::fpt_word_t hwdata,
  output fpt_pkg::fpt_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flash fetch port from core and debugger
  input wire logic fl_valid,
  input wire logic [17:0] fl_addr,
  input wire logic fl_instr,
  output logic fl_ready,
  output logic fl_rvalid,
  output logic fl_fault,
  output fpt_pkg::fpt_word_t fl_rdata,
  // Access interrupt
  output logic access_irq,
  // Bit-band alias decode
  input wire logic [31:0] bb_addr,
  input wire logic [7:0] bb_byte_in,
  input wire logic bb_wval,
  output logic bb_hit,
  output logic [31:0] bb_sram_addr,
  output logic bb_rbit,
  output logic [7:0] bb_byte_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Protection block of a flash byte address.
  function automatic logic [6:0] blk_of(input logic [17:0] a);
    return a[17:11];
  endfunction : blk_of

  // Policy bit of one block.
  function automatic logic pick(input logic [127:0] v, input logic [6:0] i);
    return v[i];
  endfunction : pick

  // ----------------------------------------------------------------
  // AHB-Lite bus phases
  // ----------------------------------------------------------------
  logic wr_pend, rd_pend, next_wr_pend, next_rd_pend;
  logic [7:0] ap_off, next_ap_off;
  fpt_pkg::fpt_word_t next_hrdata, rd_mux;
  logic ap_take;

  // Reads take one wait state so hrdata comes from a flop and sees the last write.
  always_comb begin
    ap_take = hsel && hready && htrans[1];
    next_wr_pend = ap_take && hwrite;
    next_rd_pend = ap_take && !hwrite;
    next_ap_off = ap_take ? haddr[7:0] : ap_off;
    next_hrdata = rd_pend ? rd_mux : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ap_off <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      ap_off <= next_ap_off;
      hrdata <= next_hrdata;
    end
  end

  assign hreadyout = !rd_pend;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [17:0] fma, next_fma;
  fpt_pkg::fpt_word_t fmd, next_fmd;
  logic [7:0] usec, next_usec;
  logic [1:0] imask, next_imask, ris, next_ris, ev_set;
  logic ctl_wr, clr_wr;

  always_comb begin
    ctl_wr = wr_pend && ap_off == `FPT_OFF_CTRL && hwdata[31:16] == `FPT_KEY;
    clr_wr = wr_pend && ap_off == `FPT_OFF_MISC;
    next_fma = (wr_pend && ap_off == `FPT_OFF_ADDR) ? hwdata[17:0] : fma;
    next_fmd = (wr_pend && ap_off == `FPT_OFF_DATA) ? hwdata : fmd;
    next_usec = (wr_pend && ap_off == `FPT_OFF_USEC) ? hwdata[7:0] : usec;
    next_imask = (wr_pend && ap_off == `FPT_OFF_IM) ? hwdata[1:0] : imask;
    // A new event wins over a clear in the same cycle.
    next_ris = (ris & ~(clr_wr ? hwdata[1:0] : 2'b00)) | ev_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fma <= 18'h00000;
      fmd <= 32'h00000000;
      usec <= 8'(`FPT_USEC_RST);
      imask <= 2'b00;
      ris <= 2'b00;
    end else begin
      fma <= next_fma;
      fmd <= next_fmd;
      usec <= next_usec;
      imask <= next_imask;
      ris <= next_ris;
    end
  end

  assign access_irq = |(ris & imask);

  // ----------------------------------------------------------------
  // Protection bits
  // ----------------------------------------------------------------
  // Committed bits live in the nonvolatile store; pending bits are what policy uses.
  logic [127:0] rp_nv, pp_nv, rp, pp, next_rp_nv, next_pp_nv, next_rp, next_pp;
  logic por_seen, commit;

  assign commit = ctl_wr && hwdata[`FPT_CTL_COMMIT];

  // Each policy word can only lose ones from software writes; a power-on reset reloads it from the store.
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_word
      logic rp_hit, pp_hit;
      assign rp_hit = wr_pend && ap_off == 8'(`FPT_OFF_RP0 + 4 * n);
      assign pp_hit = wr_pend && ap_off == 8'(`FPT_OFF_PP0 + 4 * n);
      assign next_rp[32*n+:32] = por_seen ? rp_nv[32*n+:32] :
        rp[32*n+:32] & (rp_hit ? hwdata : `FPT_ONES);
      assign next_pp[32*n+:32] = por_seen ? pp_nv[32*n+:32] :
        pp[32*n+:32] & (pp_hit ? hwdata : `FPT_ONES);
    end
  endgenerate

  always_comb begin
    next_rp_nv = commit ? (rp_nv & rp) : rp_nv;
    next_pp_nv = commit ? (pp_nv & pp) : pp_nv;
  end

  // Only a blank store holds factory ones; no ordinary reset touches it.
  always_ff @(posedge hclk or negedge nv_blank_n) begin
    if (!nv_blank_n) begin
      rp_nv <= {4{`FPT_ONES}};
      pp_nv <= {4{`FPT_ONES}};
    end else begin
      rp_nv <= next_rp_nv;
      pp_nv <= next_pp_nv;
    end
  end

  // Power-on reset only raises a flag; the copy from the store is clocked.
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      por_seen <= 1'b1;
    end else begin
      por_seen <= 1'b0;
    end
  end

  // Pending bits have no reset of their own so system resets leave them.
  always_ff @(posedge hclk) begin
    rp <= next_rp;
    pp <= next_pp;
  end

  // ----------------------------------------------------------------
  // Program and erase engine
  // ----------------------------------------------------------------
  fpt_pkg::fpt_state_e state, next_state;
  logic [2:0] op, next_op;
  logic [15:0] cnt, next_cnt;
  logic [7:0] div, next_div, us_left, next_us_left;
  logic pp_ok, busy, m_re, m_we;
  logic [15:0] m_addr;
  fpt_pkg::fpt_word_t m_wdata, m_rdata;

  assign busy = state != fpt_pkg::ST_IDLE;
  assign pp_ok = pick(pp, blk_of(fma));

  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_div = div;
    next_us_left = us_left;
    ev_set = 2'b00;
    case (state)
      fpt_pkg::ST_IDLE: begin
        if (ctl_wr && hwdata[`FPT_CTL_WRITE]) begin
          if (pp_ok) begin
            next_state = fpt_pkg::ST_RD;
            next_op = 3'b001;
            next_cnt = fma[17:2];
          end else begin
            ev_set[`FPT_INT_ACC] = 1'b1;
          end
        end else if (ctl_wr && hwdata[`FPT_CTL_ERASE]) begin
          if (pp_ok) begin
            next_state = fpt_pkg::ST_ERASE;
            next_op = 3'b010;
            next_cnt = {fma[17:10], 8'h00};
          end else begin
            ev_set[`FPT_INT_ACC] = 1'b1;
          end
        end else if (ctl_wr && hwdata[`FPT_CTL_MERASE]) begin
          // A mass erase would touch every block, so any protected block stops it.
          if (&pp) begin
            next_state = fpt_pkg::ST_ERASE;
            next_op = 3'b100;
            next_cnt = 16'h0000;
          end else begin
            ev_set[`FPT_INT_ACC] = 1'b1;
          end
        end
      end
      fpt_pkg::ST_RD: begin
        next_state = fpt_pkg::ST_WAIT;
        next_div = usec;
        next_us_left = `FPT_WRITE_US;
      end
      fpt_pkg::ST_WAIT: begin
        // The reload value sets the cycles per microsecond of the write pulse.
        if (div == 8'h00) begin
          next_div = usec;
          if (us_left == 8'h01) begin
            next_state = fpt_pkg::ST_PROG;
          end else begin
            next_us_left = us_left - 8'h01;
          end
        end else begin
          next_div = div - 8'h01;
        end
      end
      fpt_pkg::ST_PROG: begin
        next_state = fpt_pkg::ST_IDLE;
        next_op = 3'b000;
        ev_set[`FPT_INT_PRG] = 1'b1;
      end
      fpt_pkg::ST_ERASE: begin
        next_cnt = cnt + 16'h0001;
        if ((op[2] && cnt == `FPT_FLASH_LAST) || (!op[2] && cnt[7:0] == `FPT_BLK_LAST)) begin
          next_state = fpt_pkg::ST_IDLE;
          next_op = 3'b000;
          ev_set[`FPT_INT_PRG] = 1'b1;
        end
      end
      default: begin
        next_state = fpt_pkg::ST_IDLE;
        next_op = 3'b000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= fpt_pkg::ST_IDLE;
      op <= 3'b000;
      cnt <= 16'h0000;
      div <= 8'h00;
      us_left <= 8'h00;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      div <= next_div;
      us_left <= next_us_left;
    end
  end

  // ----------------------------------------------------------------
  // Fetch port and memory access
  // ----------------------------------------------------------------
  logic fl_take, fl_deny, next_rvalid, next_fault;
  fpt_pkg::fpt_word_t next_fl_rdata;
  logic rd_live;

  // No read queue: the array has one port and the engine owns it while busy.
  assign fl_ready = !busy;
  assign fl_take = fl_valid && !busy;
  assign fl_deny = !fl_instr && !pick(rp, blk_of(fl_addr));

  always_comb begin
    m_re = (state == fpt_pkg::ST_RD) || (fl_take && !fl_deny);
    m_we = (state == fpt_pkg::ST_PROG) || (state == fpt_pkg::ST_ERASE);
    m_addr = busy ? cnt : fl_addr[17:2];
    m_wdata = (state == fpt_pkg::ST_ERASE) ? `FPT_ONES : (m_rdata & fmd);
    next_rvalid = fl_take && !fl_deny;
    next_fault = fl_take && fl_deny;
    next_fl_rdata = rd_live ? m_rdata : fl_rdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_live <= 1'b0;
      fl_rvalid <= 1'b0;
      fl_fault <= 1'b0;
      fl_rdata <= 32'h00000000;
    end else begin
      rd_live <= next_rvalid;
      fl_rvalid <= next_rvalid;
      fl_fault <= next_fault;
      fl_rdata <= next_fl_rdata;
    end
  end

  // The answer word is taken from the array one cycle after fl_rvalid rises.
  fpt_flash_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .re(m_re),
    .we(m_we),
    .addr(m_addr),
    .wdata(m_wdata),
    .rdata(m_rdata)
  );

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    case (ap_off)
      `FPT_OFF_ADDR: rd_mux = {14'h0000, fma};
      `FPT_OFF_DATA: rd_mux = fmd;
      `FPT_OFF_CTRL: rd_mux = {29'h00000000, op};
      `FPT_OFF_RIS: rd_mux = {30'h00000000, ris};
      `FPT_OFF_IM: rd_mux = {30'h00000000, imask};
      `FPT_OFF_MIS, `FPT_OFF_MISC: rd_mux = {30'h00000000, ris & imask};
      `FPT_OFF_USEC: rd_mux = {24'h000000, usec};
      8'h40: rd_mux = rp[31:0];
      8'h44: rd_mux = rp[63:32];
      8'h48: rd_mux = rp[95:64];
      8'h4C: rd_mux = rp[127:96];
      8'h50: rd_mux = pp[31:0];
      8'h54: rd_mux = pp[63:32];
      8'h58: rd_mux = pp[95:64];
      8'h5C: rd_mux = pp[127:96];
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Bit-band alias decode
  // ----------------------------------------------------------------
  logic next_bb_hit, next_bb_rbit;
  logic [31:0] next_bb_sram;
  logic [7:0] next_bb_byte;

  // The merged byte is written back in one access, so no other bit can change.
  always_comb begin
    next_bb_hit = (bb_addr & `FPT_BB_MASK) == `FPT_BB_BASE;
    next_bb_sram = `FPT_SRAM_BASE + {12'h000, bb_addr[24:5]};
    next_bb_rbit = bb_byte_in[bb_addr[4:2]];
    next_bb_byte = bb_byte_in;
    next_bb_byte[bb_addr[4:2]] = bb_wval;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bb_hit <= 1'b0;
      bb_sram_addr <= 32'h00000000;
      bb_rbit <= 1'b0;
      bb_byte_out <= 8'h00;
    end else begin
      bb_hit <= next_bb_hit;
      bb_sram_addr <= next_bb_sram;
      bb_rbit <= next_bb_rbit;
      bb_byte_out <= next_bb_byte;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  erase_ones_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == fpt_pkg::ST_ERASE |-> m_we && m_wdata == `FPT_ONES)
    else $error("erase writes a non-ones word");
  prog_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == fpt_pkg::ST_PROG |-> (m_wdata & ~m_rdata) == 32'h00000000)
    else $error("program sets a bit");
  blocked_prog_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == fpt_pkg::ST_IDLE && ctl_wr && hwdata[`FPT_CTL_WRITE] && !pp_ok
      |=> state == fpt_pkg::ST_IDLE && ris[`FPT_INT_ACC])
    else $error("protected program not refused");
  read_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fl_take && !fl_instr && !pick(rp, blk_of(fl_addr)) |=> fl_fault && !fl_rvalid)
    else $error("protected data read not faulted");
  fetch_ok_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fl_take && fl_instr |=> fl_rvalid && !fl_fault)
    else $error("instruction fetch refused");
  irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !imask[`FPT_INT_ACC] && !ris[`FPT_INT_PRG] |-> !access_irq)
    else $error("masked access event raised interrupt");
  commit_only_a: assert property (@(posedge hclk) disable iff (!nv_blank_n)
    $past(nv_blank_n) |->
      (pp_nv & ~$past(pp_nv)) == 128'h0 && (rp_nv & ~$past(rp_nv)) == 128'h0)
    else $error("committed bit returned to one");
  stall_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(busy) |-> !fl_ready [*2])
    else $error("fetch not stalled during operation");
  clear_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_wr && hwdata[`FPT_INT_ACC] && !ev_set[`FPT_INT_ACC] |=> !ris[`FPT_INT_ACC])
    else $error("raw status not cleared");
  bb_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> bb_sram_addr == `FPT_SRAM_BASE + {12'h000, $past(bb_addr[24:5])})
    else $error("alias decode wrong");
endmodule : fpt_flash_protect

// ==== verif/fpt_fetch_model.sv ====
// Core and debugger model that issues flash fetches and data reads.
`timescale 1ns/1ps
module fpt_fetch_model (
  // Clock
  input wire logic hclk,
  // Flash port
  input wire logic fl_ready,
  output logic fl_valid,
  output logic [17:0] fl_addr,
  output logic fl_instr
);
  // Idle state at time zero.
  initial begin
    fl_valid = 1'b0;
    fl_addr = 18'h00000;
    fl_instr = 1'b0;
  end

  // A request is held until taken; afterwards the lines are inverted so
  // that a stale address can never pass for a live one.
  task automatic fetch(input logic [17:0] a, input logic ins);
    @(posedge hclk);
    fl_valid <= 1'b1;
    fl_addr <= a;
    fl_instr <= ins;
    do @(posedge hclk); while (fl_ready !== 1'b1);
    fl_valid <= 1'b0;
    fl_addr <= ~a;
    fl_instr <= ~ins;
  endtask : fetch
endmodule : fpt_fetch_model

// ==== verif/fpt_flash_protect_tb.sv ====
// Self-checking bench for the flash protection block.
`timescale 1ns/1ps
`include "fpt_consts.svh"
module fpt_flash_protect_tb;
  logic hclk, hresetn, por_n, nv_blank_n, hsel, hwrite, chk;
  logic bb_wval, bb_go, rd_dp, rv_d, bb_d;
  logic [31:0] haddr, bb_addr, xs, rr, bb_sram_addr;
  logic [1:0] htrans;
  logic [7:0] bb_byte_in, bb_byte_out;
  fpt_pkg::fpt_word_t hwdata, hrdata, fl_rdata;
  wire logic hready;
  logic hresp, fl_ready, fl_rvalid, fl_fault, access_irq, bb_hit, bb_rbit;
  logic fl_valid, fl_instr;
  logic [17:0] fl_addr;
  logic [41:0] be;
  logic [32:0] fq[$];
  logic [41:0] bq[$];
  int mismatches, checks_done;

  fpt_flash_protect dut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n),
    .nv_blank_n(nv_blank_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .fl_valid(fl_valid), .fl_addr(fl_addr),
    .fl_instr(fl_instr), .fl_ready(fl_ready), .fl_rvalid(fl_rvalid), .fl_fault(fl_fault),
    .fl_rdata(fl_rdata), .access_irq(access_irq), .bb_addr(bb_addr),
    .bb_byte_in(bb_byte_in), .bb_wval(bb_wval), .bb_hit(bb_hit),
    .bb_sram_addr(bb_sram_addr), .bb_rbit(bb_rbit), .bb_byte_out(bb_byte_out));
  fpt_fetch_model cpu (.hclk(hclk), .fl_ready(fl_ready), .fl_valid(fl_valid),
    .fl_addr(fl_addr), .fl_instr(fl_instr));

  // Clock at 50 MHz.
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // --------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------
  // Counts every compare and reports a difference at once.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pops the oldest note; a result with no note waiting is a mismatch.
  task automatic take(input logic [32:0] seen);
    if (fq.size() == 0) check(64'h1, 64'h0);
    else check(seen, fq.pop_front());
  endtask : take

  // Leftover notes mean an answer never came.
  task automatic final_report();
    if (fq.size() != 0 || bq.size() != 0) mismatches++;
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Watches outputs at each edge, before that edge's updates land.
  always @(posedge hclk) begin
    if (rd_dp === 1'b1 && hready === 1'b1) take({1'b0, hrdata});
    if (fl_fault === 1'b1) take({1'b1, 32'h0});
    if (rv_d === 1'b1) take({1'b0, fl_rdata});
    if (bb_d === 1'b1) begin
      be = bq.pop_front();
      check(be[41] ? {bb_hit, bb_sram_addr, bb_rbit, bb_byte_out} : {41'h0, bb_hit}, be);
    end
    rv_d <= fl_rvalid;
    bb_d <= bb_go;
    if (hready === 1'b1) rd_dp <= hsel && htrans[1] && !hwrite && chk;
  end

  // --------------------------------------------------------------
  // Drivers
  // --------------------------------------------------------------
  // One AHB-Lite single word transfer; waits only on hready.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic c, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    chk <= c;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    check(hresp, 1'b0);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 1'b0, rr);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    fq.push_back({1'b0, e});
    ahb(1'b0, a, 32'h0, 1'b1, rr);
  endtask : rd

  // Starts an engine command with the key and polls until it is idle.
  task automatic op(input logic [3:0] cmd);
    wr(`FPT_OFF_CTRL, {`FPT_KEY, 12'h000, cmd});
    for (int i = 0; i < 400; i++) begin
      ahb(1'b0, `FPT_OFF_CTRL, 32'h0, 1'b0, rr);
      if (rr === 32'h0) break;
    end
    check(rr, 32'h0);
  endtask : op

  task automatic fl(input logic [17:0] a, input logic ins, input logic [32:0] e);
    fq.push_back(e);
    cpu.fetch(a, ins);
    repeat (3) @(posedge hclk);
  endtask : fl

  task automatic por_pulse();
    @(posedge hclk);
    por_n <= 1'b0;
    repeat (2) @(posedge hclk);
    por_n <= 1'b1;
  endtask : por_pulse

  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : nxt

  // Random alias addresses, each put in or outside the alias window by one random bit.
  task automatic bitband();
    logic [31:0] a;
    logic [7:0] nb;
    for (int i = 0; i < 12; i++) begin
      @(posedge hclk);
      xs = nxt(xs);
      a = {xs[26] ? 7'h11 : 7'h20, xs[24:0]};
      nb = xs[31:24];
      nb[a[4:2]] = xs[25];
      bq.push_back(xs[26] ? {1'b1, `FPT_SRAM_BASE + ((a - `FPT_BB_BASE) >> 5),
        xs[24 + a[4:2]], nb} : 42'h0);
      bb_addr <= a;
      bb_byte_in <= xs[31:24];
      bb_wval <= xs[25];
      bb_go <= 1'b1;
    end
    @(posedge hclk);
    bb_go <= 1'b0;
  endtask : bitband

  // Watchdog sized well above the longest run of the sequence.
  initial begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    final_report();
  end

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    {hresetn, por_n, nv_blank_n, hsel, hwrite, chk, bb_wval, bb_go} = 8'h00;
    {htrans, haddr, hwdata, bb_addr, bb_byte_in} = '0;
    xs = 32'd65;
    repeat (2) @(posedge hclk);
    nv_blank_n <= 1'b1;
    repeat (2) @(posedge hclk);
    por_n <= 1'b1;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(`FPT_OFF_USEC, 32'h31);
    rd(`FPT_OFF_RP0, `FPT_ONES);
    rd(`FPT_OFF_PP0 + 8'h0C, `FPT_ONES);
    rd(8'h3C, 32'h0);
    wr(`FPT_OFF_USEC, 32'(`FPT_CLK_MHZ - 1));
    wr(`FPT_OFF_ADDR, 32'h800);
    wr(`FPT_OFF_CTRL, 32'h00000002);
    rd(`FPT_OFF_CTRL, 32'h0);
    op(4'h2);
    wr(`FPT_OFF_ADDR, 32'h0);
    op(4'h2);
    fl(18'h00000, 1'b0, {1'b0, `FPT_ONES});
    wr(`FPT_OFF_DATA, 32'h0F0F00FF);
    op(4'h1);
    wr(`FPT_OFF_DATA, 32'hFFFF0F0F);
    op(4'h1);
    fl(18'h00000, 1'b0, {1'b0, 32'h0F0F000F});
    // Read-protect block 0; a write of ones must not set bits back.
    wr(`FPT_OFF_RP0, 32'hFFFFFFFE);
    wr(`FPT_OFF_RP0, `FPT_ONES);
    rd(`FPT_OFF_RP0, 32'hFFFFFFFE);
    fl(18'h00000, 1'b0, {1'b1, 32'h0});
    fl(18'h00400, 1'b0, {1'b1, 32'h0});
    fl(18'h007FC, 1'b0, {1'b1, 32'h0});
    fl(18'h00000, 1'b1, {1'b0, 32'h0F0F000F});
    fl(18'h00800, 1'b0, {1'b0, `FPT_ONES});
    wr(`FPT_OFF_DATA, 32'hFFFFFFF0);
    op(4'h1);
    fl(18'h00000, 1'b1, {1'b0, 32'h0F0F0000});
    // Program-protect block 0 with the access interrupt unmasked.
    wr(`FPT_OFF_PP0, 32'hFFFFFFFE);
    wr(`FPT_OFF_IM, 32'h1);
    wr(`FPT_OFF_MISC, 32'h3);
    wr(`FPT_OFF_DATA, 32'h0);
    op(4'h1);
    ahb(1'b0, `FPT_OFF_RIS, 32'h0, 1'b0, rr);
    check(rr[0], 1'b1);
    check(access_irq, 1'b1);
    fl(18'h00000, 1'b1, {1'b0, 32'h0F0F0000});
    wr(`FPT_OFF_MISC, 32'h1);
    ahb(1'b0, `FPT_OFF_RIS, 32'h0, 1'b0, rr);
    check(rr[0], 1'b0);
    check(access_irq, 1'b0);
    wr(`FPT_OFF_IM, 32'h0);
    wr(`FPT_OFF_ADDR, 32'h400);
    op(4'h2);
    ahb(1'b0, `FPT_OFF_RIS, 32'h0, 1'b0, rr);
    check(rr[0], 1'b1);
    check(access_irq, 1'b0);
    // Fetches wait out a running erase.
    wr(`FPT_OFF_ADDR, 32'h800);
    wr(`FPT_OFF_CTRL, {`FPT_KEY, 16'h0002});
    repeat (3) @(posedge hclk);
    check(fl_ready, 1'b0);
    fl(18'h00800, 1'b1, {1'b0, `FPT_ONES});
    // System reset keeps pending bits; power-on reset restores them.
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(`FPT_OFF_RP0, 32'hFFFFFFFE);
    por_pulse();
    rd(`FPT_OFF_RP0, `FPT_ONES);
    rd(`FPT_OFF_PP0, `FPT_ONES);
    wr(`FPT_OFF_PP0, 32'hFFFFFFFD);
    op(4'h8);
    por_pulse();
    wr(`FPT_OFF_PP0, `FPT_ONES);
    rd(`FPT_OFF_PP0, 32'hFFFFFFFD);
    // Block 1 is now read-only: a program is refused, reads still see erased ones.
    wr(`FPT_OFF_ADDR, 32'h804);
    wr(`FPT_OFF_DATA, 32'h0);
    op(4'h1);
    fl(18'h00804, 1'b0, {1'b0, `FPT_ONES});
    // A mass erase is refused while any block is program-protected.
    wr(`FPT_OFF_MISC, 32'h1);
    op(4'h4);
    ahb(1'b0, `FPT_OFF_RIS, 32'h0, 1'b0, rr);
    check(rr[0], 1'b1);
    fl(18'h00000, 1'b1, {1'b0, 32'h0F0F0000});
    bitband();
    repeat (5) @(posedge hclk);
    final_report();
  end
endmodule : fpt_flash_protect_tb
